//--- rtl/serial_shift_port.sv
`timescale 1ns/100ps

// Operation
// - Eight-bit shift register between data pins
// - Master uses internal clock, slave external
// - Port works only while port select set
// - Master clock period 2, 4 or 8 cycles
// - Busy set starts; cleared after eight bits
// - Software clearing busy stops shifting early
// - Enabled interrupt request on eight-bit completion
// - Master alone initiates every exchange
// - Config bits pick drive/float and master/slave
// - Clock stops after eight pulses
// - Clock idle level follows port data bit 5
// - Normal: sample rising, shift out falling
// - Alternate: sample falling, change out rising
// - Phase select lives in pin 6 config bit
// - Phase normal when select equals clock bit
// - Phase select resets cleared
module serial_shift_port #(
   parameter int DATA_W = serial_shift_pkg::XFER_BITS
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        data_in,
   input  wire logic        shift_clock_in,
   output logic             shift_clock_out,
   output logic             shift_clock_oe,
   output logic             data_out,
   output logic             data_out_oe,
   output logic             xfer_done_irq
);

   localparam int CW = $clog2(DATA_W + 1);

   // Register state
   logic [7:0]        ctrl_q;
   logic [7:0]        ctrl_d;
   logic [7:0]        port_data_q;
   logic [7:0]        port_data_d;
   logic [7:0]        port_cfg_q;
   logic [7:0]        port_cfg_d;
   logic [31:0]       prdata_q;
   logic [31:0]       prdata_d;

   // Shift engine state
   logic [DATA_W-1:0] sreg_q;
   logic [DATA_W-1:0] sreg_d;
   logic              busy_q;
   logic              busy_d;
   logic [CW-1:0]     cnt_q;
   logic [CW-1:0]     cnt_d;
   logic [2:0]        div_q;
   logic [2:0]        div_d;
   logic              sck_q;
   logic              sck_d;
   logic              prev_clk_q;
   logic              prev_clk_d;
   logic              samp_q;
   logic              samp_d;
   logic              have_q;
   logic              have_d;
   logic              dout_q;
   logic              dout_d;
   logic              irq_q;
   logic              irq_d;

   // Decoded controls and events
   logic              port_sel;
   logic              master;
   logic              idle_lvl;
   logic              normal;
   logic [2:0]        half;
   logic              access;
   logic              wr;
   logic              mapped;
   logic              m_edge;
   logic              s_edge;
   logic              any_edge;
   logic              new_lvl;
   logic              in_edge;
   logic              out_edge;
   logic              trailing;
   logic              done;
   logic              din_s;
   logic              clk_s;

   // Pins cross in through two flops; that lag leaves master receive sound only at the slow rate
   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in ({data_in, shift_clock_in}),
      .sync_out ({din_s, clk_s})
   );

   // Control decode
   always_comb begin
      port_sel = ctrl_q[serial_shift_pkg::CTL_PORT_SEL_BIT];
      master   = port_cfg_q[serial_shift_pkg::PIN_CLOCK_BIT];
      idle_lvl = port_data_q[serial_shift_pkg::PIN_CLOCK_BIT];
      normal   = port_cfg_q[serial_shift_pkg::PIN_PHASE_BIT] == idle_lvl;
      if (ctrl_q[serial_shift_pkg::CTL_RATE_HIGH_BIT]) begin
         half = serial_shift_pkg::HALF_SLOW;
      end else if (ctrl_q[serial_shift_pkg::CTL_RATE_LOW_BIT]) begin
         half = serial_shift_pkg::HALF_MID;
      end else begin
         half = serial_shift_pkg::HALF_FAST;
      end
   end

   // Bus decode; zero wait states since read data is staged in setup
   always_comb begin
      access = psel & penable;
      wr     = access & pwrite;
      mapped = (paddr == serial_shift_pkg::OFS_CONTROL) ||
               (paddr == serial_shift_pkg::OFS_STATUS_WORD) ||
               (paddr == serial_shift_pkg::OFS_SHIFT_DATA) ||
               (paddr == serial_shift_pkg::OFS_PORT_DATA) ||
               (paddr == serial_shift_pkg::OFS_PORT_CFG);
   end

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata  = prdata_q;

   // Clock edges: generated in master, detected on the pin in slave
   always_comb begin
      m_edge   = port_sel & master & busy_q & (div_q == half - 3'h1);
      s_edge   = port_sel & ~master & busy_q & (clk_s != prev_clk_q);
      any_edge = m_edge | s_edge;
      new_lvl  = master ? ~sck_q : clk_s;
      in_edge  = any_edge & (normal ? new_lvl : ~new_lvl);
      out_edge = any_edge & (normal ? ~new_lvl : new_lvl);
      trailing = any_edge & (new_lvl == idle_lvl);
      done     = trailing & (cnt_q == CW'(DATA_W - 1));
   end

   // Register file next values
   always_comb begin
      ctrl_d      = ctrl_q;
      port_data_d = port_data_q;
      port_cfg_d  = port_cfg_q;
      prdata_d    = prdata_q;
      if (wr && paddr == serial_shift_pkg::OFS_CONTROL) begin
         ctrl_d = {4'h0, pwdata[serial_shift_pkg::CTL_FIELD_W-1:0]};
      end
      if (wr && paddr == serial_shift_pkg::OFS_PORT_DATA) begin
         port_data_d = pwdata[7:0];
      end
      if (wr && paddr == serial_shift_pkg::OFS_PORT_CFG) begin
         port_cfg_d = pwdata[7:0];
      end
      // Read data is captured in the setup cycle
      if (psel && !penable) begin
         unique case (paddr)
            serial_shift_pkg::OFS_CONTROL:     prdata_d = {24'h0, ctrl_q};
            serial_shift_pkg::OFS_STATUS_WORD: prdata_d = 32'({4'(cnt_q), 7'h00, busy_q}) <<
                                                          (serial_shift_pkg::PSW_COUNT_LSB -
                                                           serial_shift_pkg::PSW_COUNT_W - 4);
            serial_shift_pkg::OFS_SHIFT_DATA:  prdata_d = 32'(sreg_q);
            serial_shift_pkg::OFS_PORT_DATA:   prdata_d = {24'h0, port_data_q};
            serial_shift_pkg::OFS_PORT_CFG:    prdata_d = {24'h0, port_cfg_q};
            default:                           prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Register file storage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q      <= serial_shift_pkg::CONTROL_RESET;
         port_data_q <= serial_shift_pkg::PORT_DATA_RESET;
         port_cfg_q  <= serial_shift_pkg::PORT_CFG_RESET;
         prdata_q    <= 32'h0000_0000;
      end else begin
         ctrl_q      <= ctrl_d;
         port_data_q <= port_data_d;
         port_cfg_q  <= port_cfg_d;
         prdata_q    <= prdata_d;
      end
   end

   // Shift engine next values
   always_comb begin
      sreg_d     = sreg_q;
      busy_d     = busy_q;
      cnt_d      = cnt_q;
      samp_d     = samp_q;
      have_d     = have_q;
      dout_d     = dout_q;
      prev_clk_d = clk_s;
      irq_d      = done & ctrl_q[serial_shift_pkg::CTL_INT_EN_BIT];

      // Divider runs only during a master transfer
      if (!busy_q || !master || !port_sel || m_edge) begin
         div_d = 3'h0;
      end else begin
         div_d = div_q + 3'h1;
      end

      // Clock rests at the idle level outside transfers
      if (!busy_q) begin
         sck_d = idle_lvl;
      end else if (m_edge) begin
         sck_d = ~sck_q;
      end else begin
         sck_d = sck_q;
      end

      // Normal phase keeps the sample until the falling edge shifts it in
      if (normal) begin
         if (in_edge && done) begin
            sreg_d = {sreg_q[DATA_W-2:0], din_s};
            have_d = 1'b0;
         end else if (in_edge) begin
            samp_d = din_s;
            have_d = 1'b1;
         end
         if (out_edge && have_q) begin
            sreg_d = {sreg_q[DATA_W-2:0], samp_q};
            dout_d = sreg_q[DATA_W-2];
            have_d = 1'b0;
         end else if (out_edge) begin
            dout_d = sreg_q[DATA_W-1];
         end
      end else begin
         if (in_edge) begin
            sreg_d = {sreg_q[DATA_W-2:0], din_s};
         end
         if (out_edge) begin
            dout_d = sreg_q[DATA_W-1];
         end
      end

      // Count whole pulses; the eighth return to idle ends the transfer
      if (trailing) begin
         cnt_d = cnt_q + CW'(1);
      end
      if (done) begin
         busy_d = 1'b0;
      end

      // Loading while idle also presents the first bit
      if (wr && paddr == serial_shift_pkg::OFS_SHIFT_DATA) begin
         sreg_d = pwdata[DATA_W-1:0];
         if (!busy_q) begin
            dout_d = pwdata[DATA_W-1];
         end
      end

      // Software write wins over a completion in the same cycle
      if (wr && paddr == serial_shift_pkg::OFS_STATUS_WORD) begin
         busy_d = pwdata[serial_shift_pkg::PSW_BUSY_BIT];
         if (pwdata[serial_shift_pkg::PSW_BUSY_BIT] && !busy_q) begin
            cnt_d  = '0;
            have_d = 1'b0;
            dout_d = sreg_q[DATA_W-1];
         end
      end
   end

   // Shift engine storage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sreg_q     <= DATA_W'(serial_shift_pkg::SHIFT_RESET);
         busy_q     <= 1'b0;
         cnt_q      <= '0;
         div_q      <= 3'h0;
         sck_q      <= 1'b0;
         prev_clk_q <= 1'b0;
         samp_q     <= 1'b0;
         have_q     <= 1'b0;
         dout_q     <= 1'b0;
         irq_q      <= 1'b0;
      end else begin
         sreg_q     <= sreg_d;
         busy_q     <= busy_d;
         cnt_q      <= cnt_d;
         div_q      <= div_d;
         sck_q      <= sck_d;
         prev_clk_q <= prev_clk_d;
         samp_q     <= samp_d;
         have_q     <= have_d;
         dout_q     <= dout_d;
         irq_q      <= irq_d;
      end
   end

   // Pin routing; with select off the pins are left to the general port
   assign shift_clock_out = sck_q;
   assign shift_clock_oe  = port_sel & master;
   assign data_out        = dout_q;
   assign data_out_oe     = port_sel &
                            port_cfg_q[serial_shift_pkg::PIN_DATA_OUT_BIT];
   assign xfer_done_irq   = irq_q;

endmodule : serial_shift_port

//--- rtl/serial_shift_pkg.sv
package serial_shift_pkg;

   // Byte addresses of the software-visible registers
   localparam logic [7:0] OFS_CONTROL     = 8'h00;
   localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
   localparam logic [7:0] OFS_SHIFT_DATA  = 8'h08;
   localparam logic [7:0] OFS_PORT_DATA   = 8'h0C;
   localparam logic [7:0] OFS_PORT_CFG    = 8'h10;

   // Field positions in timer_serial_control_reg
   localparam int CTL_PORT_SEL_BIT  = 0;
   localparam int CTL_RATE_LOW_BIT  = 1;
   localparam int CTL_RATE_HIGH_BIT = 2;
   localparam int CTL_INT_EN_BIT    = 3;
   localparam int CTL_FIELD_W       = 4;

   // Field positions in processor_status_word
   localparam int PSW_BUSY_BIT  = 0;
   localparam int PSW_COUNT_LSB = 8;
   localparam int PSW_COUNT_W   = 4;

   // Pin positions shared by the port data and port configuration registers
   localparam int PIN_DATA_OUT_BIT = 4;
   localparam int PIN_CLOCK_BIT    = 5;
   localparam int PIN_PHASE_BIT    = 6;

   // Reset values
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [7:0] PORT_DATA_RESET = 8'h00;
   localparam logic [7:0] PORT_CFG_RESET  = 8'h00;
   localparam logic [7:0] SHIFT_RESET     = 8'h00;

   // Transfer length and master clock periods in instruction cycles
   localparam int XFER_BITS   = 8;
   localparam int PERIOD_FAST = 2;
   localparam int PERIOD_MID  = 4;
   localparam int PERIOD_SLOW = 8;
   localparam logic [2:0] HALF_FAST = 3'(PERIOD_FAST / 2);
   localparam logic [2:0] HALF_MID  = 3'(PERIOD_MID / 2);
   localparam logic [2:0] HALF_SLOW = 3'(PERIOD_SLOW / 2);

endpackage : serial_shift_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   // First stage feeds only the second; nothing else may look at it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q   <= '0;
         stable_q <= '0;
      end else begin
         meta_q   <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;

endmodule : pin_sync

//--- sim/serial_shift_port_chk.sv
`timescale 1ns/100ps
// Watches the pins and shadows the bus writes that steer them
module serial_shift_port_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        shift_clock_out,
   input wire logic        shift_clock_oe,
   input wire logic        data_out_oe,
   input wire logic        xfer_done_irq
);
   logic [3:0] ctl_q;
   logic [7:0] cfg_q;
   logic [7:0] run_q;
   logic [4:0] tog_q;
   logic       pd_q, act_q, sck_q, wr, tg, mst;
   logic [2:0] hv;
   assign wr  = psel & penable & pwrite & pready;
   assign tg  = shift_clock_out != sck_q;
   assign mst = ctl_q[0] & cfg_q[5];
   assign hv  = ctl_q[2] ? 3'h4 : (ctl_q[1] ? 3'h2 : 3'h1);
   // Shadow registers plus toggle and spacing counters of a master transfer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {ctl_q, cfg_q, pd_q, act_q, sck_q, tog_q, run_q} <= '0;
      end else begin
         sck_q <= shift_clock_out;
         run_q <= tg ? 8'h01 : run_q + {7'h0, run_q != 8'hFF};
         if (wr && paddr == serial_shift_pkg::OFS_CONTROL) ctl_q <= pwdata[3:0];
         if (wr && paddr == serial_shift_pkg::OFS_PORT_CFG) cfg_q <= pwdata[7:0];
         if (wr && paddr == serial_shift_pkg::OFS_PORT_DATA) pd_q <= pwdata[5];
         if (act_q && tg) tog_q <= tog_q + 5'h01;
         if (act_q && tg && tog_q == 5'h0F) act_q <= 1'b0;
         if (wr && paddr == serial_shift_pkg::OFS_STATUS_WORD) begin
            if (!pwdata[0]) begin
               act_q <= 1'b0;
            end else if (!act_q && mst) begin
               act_q <= 1'b1;
               tog_q <= 5'h00;
               run_q <= 8'h00;
            end
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_done;
      $fell(act_q) && tog_q == 5'h10;
   endsequence
   AST_HALF_PERIOD: assert property (tg && act_q && mst |-> run_q == {5'h0, hv})
      else $error("shift clock half period wrong");
   AST_STOP_AFTER_EIGHT: assert property (s_done |-> $stable(shift_clock_out) [*8])
      else $error("shift clock runs past eight pulses");
   AST_IRQ_CAUSE: assert property ($rose(xfer_done_irq) && mst |-> ctl_q[3] && tog_q >= 5'h0F)
      else $error("interrupt without a completed byte");
   AST_IRQ_MASKED: assert property (!ctl_q[3] |-> !xfer_done_irq)
      else $error("interrupt while disabled");
   AST_IRQ_PULSE: assert property (xfer_done_irq |=> !xfer_done_irq)
      else $error("interrupt longer than one cycle");
   AST_DATA_OE: assert property (data_out_oe == (ctl_q[0] & cfg_q[4]))
      else $error("data pin drive wrong");
   AST_CLOCK_OE: assert property (shift_clock_oe == mst)
      else $error("clock pin drive wrong");
   AST_IDLE_LEVEL: assert property (mst && !act_q && !$past(act_q) && $stable(pd_q)
      && $stable(mst) |-> shift_clock_out == pd_q)
      else $error("clock idle level wrong");
endmodule : serial_shift_port_chk
bind serial_shift_port serial_shift_port_chk serial_shift_port_chk_inst (.clk, .rst_b, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .shift_clock_out, .shift_clock_oe,
   .data_out_oe, .xfer_done_irq);

//--- sim/spi_peer.sv
`timescale 1ns/100ps
// Far-side peripheral; in slave tests it also makes the shift clock
module spi_peer (
   input  wire logic sck_dut,
   input  wire logic sdo,
   input  wire logic ext,
   input  wire logic alt,
   output logic      sck_ext,
   output logic      sdi
);
   logic [8:0] sh;
   logic [7:0] rx;
   logic       e;
   assign e   = (ext ? sck_ext : sck_dut) ^ alt;
   assign sdi = sh[8];
   initial sh = 9'h0AA;
   initial sck_ext = 1'b0;
   // Capture edge
   always @(posedge e) rx = {rx[6:0], sdo};
   // Launch edge; past the frame the line keeps toggling, so stale bits never pass
   always @(negedge e) sh = {sh[7:0], ~sh[8]};
   task load(input logic [7:0] t, input logic pre);
      sh = pre ? {~t[7], t} : {t, ~t[0]};
      rx = 8'h00;
   endtask : load
   // Eight pulses at 200 ns; the clock stands still between frames
   task frame();
      repeat (8) begin
         #100 sck_ext <= 1'b1;
         #100 sck_ext <= 1'b0;
      end
   endtask : frame
endmodule : spi_peer

//--- sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
$display("Error %0t: got %0h want %0h", $time, (g), (e)); end end
module tb_top;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, tx, u, exp_b;
   logic [7:0]  peer_q[$], dev_q[$];
   logic [31:0] pwdata, prdata, rd, seed;
   logic        data_in, shift_clock_in, shift_clock_out, shift_clock_oe;
   logic        data_out, data_out_oe, xfer_done_irq, ext, alt;
   int          miscompares, comparisons, irqs, exp_irqs, n;
   serial_shift_port serial_shift_port_inst (.clk, .rst_b, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .data_in, .shift_clock_in,
      .shift_clock_out, .shift_clock_oe, .data_out, .data_out_oe, .xfer_done_irq);
   spi_peer spi_peer_inst (.sck_dut(shift_clock_out), .sdo(data_out), .ext, .alt,
      .sck_ext(shift_clock_in), .sdi(data_in));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // Completion pulses seen on the pin
   always @(posedge clk) if (xfer_done_irq === 1'b1) irqs++;
   function logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   // One bus transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (k == 20) miscompares++;
   endtask : apb
   // Poll busy under a bounded count
   task idle();
      n = 0;
      rd = 32'h1;
      while (rd[0] !== 1'b0 && n < 60) begin
         apb(1'b0, serial_shift_pkg::OFS_STATUS_WORD, 32'h0);
         n++;
      end
   endtask : idle
   task stop_test();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // A hang is cut short here
   initial begin
      #500000;
      miscompares++;
      stop_test();
   end
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ext, alt} = '0;
      rst_b = 1'b0;
      seed = 32'h00001B6C;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int a = 0; a <= 20; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         `CHK({er, rd}, {a == 20, 32'h0})
      end
      // Every rate code against every phase and idle pairing; the model queues
      // hold the byte that each side must end up with
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         {u, tx} = seed[15:0];
         peer_q.push_back(tx);
         dev_q.push_back(u);
         apb(1'b1, serial_shift_pkg::OFS_CONTROL, {28'h0, i[0], i[1:0], 1'b1});
         apb(1'b1, serial_shift_pkg::OFS_PORT_DATA, {26'h0, i[3], 5'h0});
         apb(1'b1, serial_shift_pkg::OFS_PORT_CFG, {25'h0, i[2], 6'h30});
         apb(1'b1, serial_shift_pkg::OFS_SHIFT_DATA, {24'h0, tx});
         alt = i[3] ^ i[2];
         spi_peer_inst.load(u, i[2]);
         apb(1'b1, serial_shift_pkg::OFS_STATUS_WORD, 32'h1);
         idle();
         `CHK({rd[11:8], rd[0]}, {4'(serial_shift_pkg::XFER_BITS), 1'b0})
         exp_irqs += i[0];
         apb(1'b0, serial_shift_pkg::OFS_SHIFT_DATA, 32'h0);
         exp_b = dev_q.pop_front();
         // The data pin lags two cycles, so master receive is judged at the slow rate
         if (i[1]) `CHK(rd[7:0], exp_b)
         exp_b = peer_q.pop_front();
         `CHK(spi_peer_inst.rx, exp_b)
         repeat (8) @(posedge clk);
      end
      `CHK(irqs, exp_irqs)
      alt = 1'b0;
      // Abort after about three pulses; no completion pulse may follow
      apb(1'b1, serial_shift_pkg::OFS_CONTROL, 32'hD);
      apb(1'b1, serial_shift_pkg::OFS_PORT_DATA, 32'h0);
      apb(1'b1, serial_shift_pkg::OFS_STATUS_WORD, 32'h1);
      repeat (24) @(posedge clk);
      apb(1'b1, serial_shift_pkg::OFS_STATUS_WORD, 32'h0);
      repeat (40) @(posedge clk);
      apb(1'b0, serial_shift_pkg::OFS_STATUS_WORD, 32'h0);
      `CHK({rd[0], irqs}, {1'b0, exp_irqs})
      // Slave: busy set while the outside clock idles, then one frame
      apb(1'b1, serial_shift_pkg::OFS_CONTROL, 32'h1);
      apb(1'b1, serial_shift_pkg::OFS_PORT_CFG, 32'h10);
      apb(1'b1, serial_shift_pkg::OFS_SHIFT_DATA, {24'h0, u});
      ext = 1'b1;
      spi_peer_inst.load(tx, 1'b0);
      apb(1'b1, serial_shift_pkg::OFS_STATUS_WORD, 32'h1);
      spi_peer_inst.frame();
      repeat (10) @(posedge clk);
      idle();
      `CHK({rd[11:8], rd[0]}, {4'(serial_shift_pkg::XFER_BITS), 1'b0})
      apb(1'b0, serial_shift_pkg::OFS_SHIFT_DATA, 32'h0);
      `CHK({rd[7:0], spi_peer_inst.rx}, {tx, u})
      stop_test();
   end
endmodule : tb_top
